/* File: rtl/rcpp_pkg.sv */
package rcpp_pkg;
  localparam int RCPP_PORT_W = 4;
  localparam int RCPP_KEY_W = 8;
  // apb map
  localparam logic [11:0] RCPP_OFS_SRC = 12'h000;
  localparam logic [11:0] RCPP_OFS_DIR = 12'h004;
  localparam logic [11:0] RCPP_OFS_PULL = 12'h008;
  localparam logic [11:0] RCPP_OFS_OUT = 12'h00C;
  localparam logic [11:0] RCPP_OFS_PIN = 12'h010;
  localparam logic [11:0] RCPP_OFS_CTRL = 12'h014;
  localparam logic [11:0] RCPP_OFS_STAT = 12'h018;
  localparam logic [11:0] RCPP_OFS_MASK = 12'h01C;
  // reset values
  localparam logic [7:0] RCPP_SRC_RST = 8'h00;
  localparam logic [3:0] RCPP_DIR_RST = 4'h0;
  localparam logic [3:0] RCPP_PULL_RST = 4'h0;
  localparam logic [3:0] RCPP_OUT_RST = 4'h0;
  localparam logic [3:0] RCPP_MASK_RST = 4'h0;
  // ctrl register fields
  localparam int RCPP_CTRL_IR = 0;
  localparam int RCPP_CTRL_STBY = 1;
  // status bit positions
  localparam int RCPP_ST_WAKE = 0;
  localparam int RCPP_ST_INT = 1;
  localparam int RCPP_ST_HANG = 2;
  localparam int RCPP_ST_TEST = 3;
  localparam int RCPP_ST_W = 4;
  typedef enum logic [1:0] {
    RCPP_RUN = 2'b01,
    RCPP_STANDBY = 2'b10
  } rcpp_pwr_t;
endpackage

/* File: rtl/rcpp_evt_if.sv */
interface rcpp_evt_if;
  import rcpp_pkg::*;
  logic [RCPP_ST_W-1:0] evt;
  logic [RCPP_ST_W-1:0] stat;
  logic [RCPP_ST_W-1:0] clr;
  logic [RCPP_ST_W-1:0] mask;
  logic irq;
  modport owner (input evt, clr, mask, output stat, irq);
  modport user (output evt, clr, mask, input stat, irq);
endinterface

/* File: rtl/rcpp_irq.sv */
module rcpp_irq (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  rcpp_evt_if.owner ev // event status and mask
);
  import rcpp_pkg::*;
  logic [RCPP_ST_W-1:0] stat_ff;
  logic [RCPP_ST_W-1:0] nxt_stat;

  // set wins over a clear in the same cycle
  assign nxt_stat = (stat_ff & ~ev.clr) | ev.evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign ev.stat = stat_ff;
  assign ev.irq = |(stat_ff & ev.mask);

  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (ev.evt != '0) |=> ((stat_ff & $past(ev.evt)) == $past(ev.evt)))
    else $error("event lost against clear");
endmodule

/* File: rtl/rcpp_wake.sv */
module rcpp_wake (
  input wire logic [7:0] key_n, // key-return levels, low = pressed
  output logic wake_req // asynchronous wake request
);
  // pure gates so a stopped clock still wakes
  assign wake_req = ~(&key_n);
endmodule

/* File: rtl/remote_ctrl_pin_ports.sv */
module remote_ctrl_pin_ports
  import rcpp_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // reset pin, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [3:0] key_return_port_a, // key return a
  input wire logic [3:0] key_return_port_b, // key return b
  output logic [3:0] key_source_port_c_o, // always low level
  output logic [3:0] key_source_port_c_oe, // pulls pin low
  output logic [3:0] key_source_port_d_o, // always low level
  output logic [3:0] key_source_port_d_oe, // pulls pin low
  input wire logic [3:0] bidir_port_e_i, // port e pin levels
  output logic [3:0] bidir_port_e_o, // port e drive levels
  output logic [3:0] bidir_port_e_oe, // port e drive enables
  output logic [3:0] bidir_port_e_pu, // port e pull-up enables
  output logic ir_carrier_out, // ir transmit, active high
  input wire logic ext_int, // external interrupt input
  input wire logic test_mode, // test mode entered via int pin
  input wire logic wdt_overflow, // watchdog overflow
  input wire logic stack_fault, // stack over or underflow
  input wire logic low_voltage, // supply below threshold
  output logic hangup_detect_out_o, // always low level
  output logic hangup_detect_out_oe, // pulls hang-up pin low
  output logic cpu_reset_n, // cpu reset, active low
  output logic osc_run, // oscillator enable
  output logic wake_req, // asynchronous wake request
  output logic standby, // standby state
  output logic irq // interrupt, active high
);
  import rcpp_pkg::*;

  logic [7:0] src_ff;
  logic [3:0] dir_ff;
  logic [3:0] pull_ff;
  logic [3:0] out_ff;
  logic ir_ff;
  logic [RCPP_ST_W-1:0] mask_ff;
  logic [31:0] prdata_ff;
  logic [3:0] pin_e_ff;
  logic int_ff;
  logic hang_ff;
  logic wake_ff;
  rcpp_pwr_t pwr_ff;
  rcpp_pwr_t nxt_pwr;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic stby_req;
  rcpp_evt_if ev ();

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  assign addr_ok = hit(paddr, RCPP_OFS_SRC) || hit(paddr, RCPP_OFS_DIR)
                   || hit(paddr, RCPP_OFS_PULL) || hit(paddr, RCPP_OFS_OUT)
                   || hit(paddr, RCPP_OFS_PIN) || hit(paddr, RCPP_OFS_CTRL)
                   || hit(paddr, RCPP_OFS_STAT) || hit(paddr, RCPP_OFS_MASK);
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  // zero wait state slave
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign stby_req = wr_en && hit(paddr, RCPP_OFS_CTRL) && pwdata[RCPP_CTRL_STBY];

  // key source drive value, a one releases the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_ff <= RCPP_SRC_RST;
    end else if (wr_en && hit(paddr, RCPP_OFS_SRC)) begin
      src_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_ff <= RCPP_DIR_RST;
      pull_ff <= RCPP_PULL_RST;
      out_ff <= RCPP_OUT_RST;
    end else begin
      if (wr_en && hit(paddr, RCPP_OFS_DIR)) begin
        dir_ff <= pwdata[3:0];
      end
      if (wr_en && hit(paddr, RCPP_OFS_PULL)) begin
        pull_ff <= pwdata[3:0];
      end
      if (wr_en && hit(paddr, RCPP_OFS_OUT)) begin
        out_ff <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_ff <= 1'b0;
    end else if (wr_en && hit(paddr, RCPP_OFS_CTRL)) begin
      ir_ff <= pwdata[RCPP_CTRL_IR];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= RCPP_MASK_RST;
    end else if (wr_en && hit(paddr, RCPP_OFS_MASK)) begin
      mask_ff <= pwdata[RCPP_ST_W-1:0];
    end
  end

  // pin sampling, inputs are synchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_e_ff <= 4'h0;
      int_ff <= 1'b0;
      hang_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      pin_e_ff <= bidir_port_e_i;
      int_ff <= ext_int;
      hang_ff <= wdt_overflow | stack_fault | low_voltage | test_mode;
      wake_ff <= wake_req;
    end
  end

  rcpp_wake u_wake (
    .key_n({key_return_port_b, key_return_port_a}),
    .wake_req(wake_req)
  );

  // standby entered by software, left on any key press
  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      RCPP_RUN: begin
        if (stby_req && !wake_req) begin
          nxt_pwr = RCPP_STANDBY;
        end
      end
      RCPP_STANDBY: begin
        if (wake_req) begin
          nxt_pwr = RCPP_RUN;
        end
      end
      default: nxt_pwr = RCPP_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ff <= RCPP_RUN;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  assign standby = (pwr_ff == RCPP_STANDBY);
  // async release so a clock stopped in standby restarts
  assign osc_run = presetn && (!standby || wake_req);
  assign cpu_reset_n = presetn;

  // event detection: rising edges of sampled levels, test_mode taken unsampled
  logic int_d_ff;
  logic hang_d_ff;
  logic test_d_ff;
  logic wake_d_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_d_ff <= 1'b0;
      hang_d_ff <= 1'b0;
      test_d_ff <= 1'b0;
      wake_d_ff <= 1'b0;
    end else begin
      int_d_ff <= int_ff;
      hang_d_ff <= hang_ff;
      test_d_ff <= test_mode;
      wake_d_ff <= wake_ff;
    end
  end

  assign ev.evt[RCPP_ST_WAKE] = wake_ff && !wake_d_ff;
  assign ev.evt[RCPP_ST_INT] = int_ff && !int_d_ff;
  assign ev.evt[RCPP_ST_HANG] = hang_ff && !hang_d_ff;
  assign ev.evt[RCPP_ST_TEST] = test_mode && !test_d_ff;
  assign ev.clr = (wr_en && hit(paddr, RCPP_OFS_STAT)) ? pwdata[RCPP_ST_W-1:0] : '0;
  assign ev.mask = mask_ff;

  rcpp_irq u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .ev(ev)
  );
  assign irq = ev.irq;

  // register read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_ff <= 32'h0000_0000;
      unique case (1'b1)
        hit(paddr, RCPP_OFS_SRC): prdata_ff[7:0] <= src_ff;
        hit(paddr, RCPP_OFS_DIR): prdata_ff[3:0] <= dir_ff;
        hit(paddr, RCPP_OFS_PULL): prdata_ff[3:0] <= pull_ff;
        hit(paddr, RCPP_OFS_OUT): prdata_ff[3:0] <= out_ff;
        hit(paddr, RCPP_OFS_PIN): prdata_ff[3:0] <= pin_e_ff;
        hit(paddr, RCPP_OFS_CTRL): prdata_ff[1:0] <= {standby, ir_ff};
        hit(paddr, RCPP_OFS_STAT): prdata_ff[RCPP_ST_W-1:0] <= ev.stat;
        hit(paddr, RCPP_OFS_MASK): prdata_ff[RCPP_ST_W-1:0] <= mask_ff;
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_ff;

  // open drain: only ever drive low
  assign key_source_port_c_o = 4'h0;
  assign key_source_port_d_o = 4'h0;
  assign key_source_port_c_oe = ~src_ff[3:0];
  assign key_source_port_d_oe = ~src_ff[7:4];
  assign bidir_port_e_oe = dir_ff;
  assign bidir_port_e_o = out_ff;
  assign bidir_port_e_pu = pull_ff & ~dir_ff;
  assign ir_carrier_out = ir_ff;
  assign hangup_detect_out_o = 1'b0;
  // delayed one cycle by sampling; board loops it to reset
  assign hangup_detect_out_oe = hang_ff;

  // reset leaves every pin passive: sources low, port e input, ir off
  a_src_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ((key_source_port_c_oe == 4'hF) && (key_source_port_d_oe == 4'hF)))
    else $error("key source not low after reset");
  a_dir_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ((bidir_port_e_oe == 4'h0) && (bidir_port_e_pu == 4'h0)))
    else $error("port e not input after reset");
  a_ir_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !ir_carrier_out)
    else $error("ir output high after reset");
  // no disable here: this one must hold while the pin is low
  a_cpu_reset: assert property (@(posedge pclk)
    !presetn |-> (!cpu_reset_n && !osc_run))
    else $error("cpu or oscillator running in reset");

  // open-drain pins may only ever pull low
  a_src_opendrain: assert property (@(posedge pclk) disable iff (!presetn)
    (key_source_port_c_o == 4'h0) && (key_source_port_d_o == 4'h0))
    else $error("key source driven high");
  a_src_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == RCPP_OFS_SRC)
    |=> ({key_source_port_d_oe, key_source_port_c_oe} == ~$past(pwdata[7:0])))
    else $error("key source write not applied");
  a_src_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == RCPP_OFS_SRC)
    |=> $stable({key_source_port_d_oe, key_source_port_c_oe}))
    else $error("key source changed without write");
  a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == RCPP_OFS_DIR) |=> (bidir_port_e_oe == $past(pwdata[3:0])))
    else $error("direction not applied");
  a_dir_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == RCPP_OFS_DIR) |=> $stable(bidir_port_e_oe))
    else $error("direction changed without write");
  a_out_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == RCPP_OFS_OUT) |=> (bidir_port_e_o == $past(pwdata[3:0])))
    else $error("port e level not applied");
  a_pull_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == RCPP_OFS_PULL)
    |=> (bidir_port_e_pu == ($past(pwdata[3:0]) & ~bidir_port_e_oe)))
    else $error("pull-up selection not applied");
  a_pull_input: assert property (@(posedge pclk) disable iff (!presetn)
    ((bidir_port_e_pu & bidir_port_e_oe) == 4'h0))
    else $error("pull-up on output bit");
  a_ir_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == RCPP_OFS_CTRL) |=> (ir_carrier_out == $past(pwdata[0])))
    else $error("ir output not updated");
  a_ir_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == RCPP_OFS_CTRL) |=> $stable(ir_carrier_out))
    else $error("ir output changed without write");

  // hang-up pin follows the fault levels one sample later
  a_hang_fault: assert property (@(posedge pclk) disable iff (!presetn)
    (wdt_overflow || stack_fault || low_voltage) |=> hangup_detect_out_oe)
    else $error("hang-up not driven on fault");
  a_hang_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !(wdt_overflow || stack_fault || low_voltage || test_mode) |=> !hangup_detect_out_oe)
    else $error("hang-up driven without cause");
  a_hang_test: assert property (@(posedge pclk) disable iff (!presetn)
    test_mode |=> hangup_detect_out_oe)
    else $error("hang-up not driven in test mode");

  sequence s_sleep;
    standby && !wake_req;
  endsequence
  sequence s_key_down;
    (key_return_port_a != 4'hF) || (key_return_port_b != 4'hF);
  endsequence
  sequence s_stby_wr;
    wr_en && (paddr == RCPP_OFS_CTRL) && pwdata[RCPP_CTRL_STBY];
  endsequence
  a_wake_exit: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep ##1 wake_req |=> !standby)
    else $error("standby not released by key");
  a_wake_any: assert property (@(posedge pclk) disable iff (!presetn)
    s_key_down |-> wake_req)
    else $error("pressed key gives no wake request");
  a_wake_none: assert property (@(posedge pclk) disable iff (!presetn)
    ((key_return_port_a == 4'hF) && (key_return_port_b == 4'hF)) |-> !wake_req)
    else $error("wake request with no key pressed");
  a_stby_enter: assert property (@(posedge pclk) disable iff (!presetn)
    s_stby_wr ##0 !wake_req |=> standby)
    else $error("standby not entered");
  // a held key would release standby at once, so entry is refused
  a_stby_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    s_stby_wr ##0 (wake_req && !standby) |=> !standby)
    else $error("standby entered with key held");
  a_osc_wake: assert property (@(posedge pclk) disable iff (!presetn)
    s_key_down |-> osc_run)
    else $error("oscillator held while key pressed");
  a_osc_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (standby && !wake_req) |-> !osc_run)
    else $error("oscillator running in standby");
  a_int_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(int_ff) |=> ev.stat[RCPP_ST_INT])
    else $error("interrupt input not flagged");
endmodule

/* File: verif/rcpp_partner.sv */
module rcpp_partner (
  input wire logic pclk, // system clock
  input wire logic [7:0] src_oe, // key source pull-downs, d then c
  input wire logic [6:0] key, // {pressed, source, return}
  output logic [7:0] ret_n, // key return levels, b then a
  input wire logic [3:0] e_o, // port e drive levels
  input wire logic [3:0] e_oe, // port e drive enables
  input wire logic [3:0] e_pu, // port e pull-ups
  input wire logic [3:0] ext_en, // far side drives port e
  input wire logic [3:0] ext_v, // far side level
  input wire logic hang_oe, // hang-up pin pulls low
  output logic rst_wire_n, // reset line tied to hang-up pin
  output logic [3:0] e_i // resolved port e pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] junk_ff = 4'h5;
  // a floating pin must not look like its last level
  always @(posedge pclk) junk_ff <= ~junk_ff;
  always_comb begin
    ret_n = 8'hFF;
    if (key[6] && src_oe[key[5:3]]) ret_n[key[2:0]] = 1'b0;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      e_i[i] = e_oe[i] ? e_o[i] : ext_en[i] ? ext_v[i] : e_pu[i] ? 1'b1 : junk_ff[i];
    end
  end
  // board wire: reset pull-up holds the line high unless hang-up pulls it
  assign rst_wire_n = !hang_oe;
endmodule

/* File: verif/testbench.sv */
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("Error %0t got %0h exp %0h", $time, got, exp); end end
module testbench import rcpp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] key_return_port_a, key_return_port_b, bidir_port_e_i;
  logic [3:0] key_source_port_c_o, key_source_port_c_oe, key_source_port_d_o;
  logic [3:0] key_source_port_d_oe, bidir_port_e_o, bidir_port_e_oe, bidir_port_e_pu;
  logic [3:0] ext_en = 0, ext_v = 0, flt = 0;
  logic [6:0] key = 0;
  logic ext_int = 0, ir_carrier_out, hangup_detect_out_o, hangup_detect_out_oe;
  logic cpu_reset_n, osc_run, wake_req, standby, irq, rst_wire_n;
  int err_count = 0, checks_done = 0;
  always #10 pclk = ~pclk;
  remote_ctrl_pin_ports DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .key_return_port_a, .key_return_port_b,
    .key_source_port_c_o, .key_source_port_c_oe, .key_source_port_d_o,
    .key_source_port_d_oe, .bidir_port_e_i, .bidir_port_e_o, .bidir_port_e_oe,
    .bidir_port_e_pu, .ir_carrier_out, .ext_int, .test_mode(flt[0]),
    .wdt_overflow(flt[3]), .stack_fault(flt[2]), .low_voltage(flt[1]),
    .hangup_detect_out_o, .hangup_detect_out_oe, .cpu_reset_n, .osc_run, .wake_req,
    .standby, .irq);
  rcpp_partner far_side (.pclk, .src_oe({key_source_port_d_oe, key_source_port_c_oe}),
    .key, .ret_n({key_return_port_b, key_return_port_a}), .e_o(bidir_port_e_o),
    .e_oe(bidir_port_e_oe), .e_pu(bidir_port_e_pu), .ext_en, .ext_v, .e_i(bidir_port_e_i),
    .hang_oe(hangup_detect_out_oe), .rst_wire_n);
  task complete_run;
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      complete_run;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK({err, rd}, {1'b0, exp})
  endtask
  initial begin
    cyc(5);
    `CHK({key_source_port_c_oe, key_source_port_d_oe, bidir_port_e_oe}, 12'hFF0)
    `CHK({bidir_port_e_pu, ir_carrier_out, hangup_detect_out_oe}, 6'h00)
    `CHK({cpu_reset_n, osc_run, irq}, 3'h0)
    cyc(1);
    presetn <= 1'b1;
    rdc(RCPP_OFS_SRC, 32'h0);
    rdc(RCPP_OFS_DIR, 32'h0);
    rdc(RCPP_OFS_PULL, 32'h0);
    rdc(RCPP_OFS_MASK, 32'h0);
    `CHK({cpu_reset_n, osc_run}, 2'b11)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    ext_en <= 4'h2;
    wr(RCPP_OFS_DIR, 32'h5);
    wr(RCPP_OFS_OUT, 32'hF);
    wr(RCPP_OFS_PULL, 32'hF);
    cyc(2);
    `CHK({bidir_port_e_oe, bidir_port_e_o & 4'h5, bidir_port_e_pu}, 12'h55A)
    rdc(RCPP_OFS_PIN, 32'hD);
    wr(RCPP_OFS_CTRL, 32'h1);
    cyc(1);
    `CHK(ir_carrier_out, 1'b1)
    wr(RCPP_OFS_SRC, 32'h0F);
    cyc(1);
    `CHK({key_source_port_c_oe, key_source_port_d_oe, key_source_port_c_o}, 12'h0F0)
    `CHK(key_source_port_d_o, 4'h0)
    key <= {1'b1, 3'd4, 3'd1};
    cyc(1);
    `CHK(wake_req, 1'b1)
    key <= {1'b1, 3'd0, 3'd5};
    cyc(1);
    `CHK(wake_req, 1'b0)
    rdc(RCPP_OFS_STAT, 32'h1);
    wr(RCPP_OFS_MASK, 32'hF);
    cyc(1);
    `CHK(irq, 1'b1)
    wr(RCPP_OFS_STAT, 32'h1);
    cyc(1);
    `CHK(irq, 1'b0)
    key <= 7'h0;
    wr(RCPP_OFS_CTRL, 32'h2);
    cyc(1);
    `CHK({standby, osc_run}, 2'b10)
    key <= {1'b1, 3'd4, 3'd1};
    cyc(2);
    `CHK({standby, osc_run}, 2'b01)
    wr(RCPP_OFS_CTRL, 32'h2);
    cyc(1);
    `CHK(standby, 1'b0)
    key <= 7'h0;
    for (int i = 0; i < 4; i++) begin
      flt <= 4'h8 >> i;
      cyc(2);
      `CHK({hangup_detect_out_oe, hangup_detect_out_o, rst_wire_n}, 3'b100)
      flt <= 4'h0;
      cyc(2);
      `CHK({hangup_detect_out_oe, rst_wire_n}, 2'b01)
    end
    ext_int <= 1'b1;
    cyc(3);
    ext_int <= 1'b0;
    rdc(RCPP_OFS_STAT, 32'hF);
    wr(RCPP_OFS_STAT, 32'hF);
    rdc(RCPP_OFS_STAT, 32'h0);
    wr(RCPP_OFS_CTRL, 32'h1);
    wr(RCPP_OFS_SRC, 32'hFF);
    presetn <= 1'b0;
    cyc(2);
    `CHK({key_source_port_c_oe, key_source_port_d_oe, ir_carrier_out}, 9'h1FE)
    `CHK({cpu_reset_n, osc_run}, 2'b00)
    presetn <= 1'b1;
    rdc(RCPP_OFS_SRC, 32'h0);
    rdc(RCPP_OFS_CTRL, 32'h0);
    rdc(RCPP_OFS_DIR, 32'h0);
    complete_run;
  end
endmodule
